// [tglpm_pkg.sv]
package tglpm_pkg;

   // ==========================================================
   // Block layout
   localparam int         BLK_W     = 66;
   localparam int         PAY_W     = 64;
   localparam int         SH_LO     = 0;
   localparam int         SH_HI     = 1;
   localparam int         TYPE_LO   = 2;
   localparam int         TYPE_HI   = 9;
   localparam int         PAY_LO    = 2;
   localparam int         PAY_HI    = 65;

   typedef logic [BLK_W-1:0] tglpm_block_t;

   // Sync header as stored, bit 0 first on the wire
   localparam logic [1:0] SH_CTRL   = 2'b01;

   // ==========================================================
   // Control block types
   localparam logic [7:0] TYPE_IDLE   = 8'h1e;
   localparam logic [7:0] TYPE_FAULT  = 8'h55;
   localparam logic [7:0] TYPE_START0 = 8'h78;
   localparam logic [7:0] TYPE_STARTA = 8'h33;
   localparam logic [7:0] TYPE_STARTB = 8'h66;

   localparam logic [7:0]  FLT_D1       = 8'h00;
   localparam logic [7:0]  FLT_D2       = 8'h00;
   localparam logic [7:0]  FLT_D3       = 8'h01;
   localparam logic [3:0]  FLT_O        = 4'h0;
   localparam logic [55:0] IDLE_PAYLOAD = 56'h0;

   // D7..D5, O4, O1, D3..D1, type, header
   localparam tglpm_block_t FAULT_BLOCK = {FLT_D3, FLT_D2, FLT_D1, FLT_O, FLT_O,
                                           FLT_D3, FLT_D2, FLT_D1, TYPE_FAULT, SH_CTRL};
   localparam tglpm_block_t IDLE_BLOCK = {IDLE_PAYLOAD, TYPE_IDLE, SH_CTRL};

   // ==========================================================
   // Descrambler, x^58 + x^39 + 1
   localparam int         DSCR_W    = 58;
   localparam int         TAP_A     = 38;
   localparam int         TAP_B     = 57;

   // ==========================================================
   // Block lock
   localparam int         OFF_W     = 7;
   localparam logic [6:0] OFF_LAST  = 7'h41;
   localparam logic [6:0] SH_WIN    = 7'h40;
   localparam logic [4:0] INVLD_MAX = 5'h10;

   typedef enum logic {LK_HUNT, LK_LOCKED} tglpm_lock_e;

   // ==========================================================
   // Rate adaptation buffer
   localparam int         FIFO_AW      = 3;
   localparam int         FIFO_ENTRIES = 8;
   localparam int         CNT_W        = 4;
   localparam logic [3:0] HI_MARK      = 4'h6;

endpackage : tglpm_pkg

// [tglpm_fifo_mem.sv]
`timescale 1ns/100ps

module tglpm_fifo_mem (
   input  wire logic                                ref_clk,
   input  wire logic                                reset_n,
   input  wire logic                                wr_en,
   input  wire logic [tglpm_pkg::FIFO_AW-1:0]       wr_addr,
   input  wire tglpm_pkg::tglpm_block_t             wr_data,
   input  wire logic [tglpm_pkg::FIFO_AW-1:0]       rd_addr,
   output tglpm_pkg::tglpm_block_t                  rd_data
);

   typedef struct packed {
      logic [tglpm_pkg::FIFO_ENTRIES-1:0][tglpm_pkg::BLK_W-1:0] mem;
      tglpm_pkg::tglpm_block_t                                  rdata;
   } tglpm_mem_s;

   tglpm_mem_s st_reg;
   tglpm_mem_s st_next;

   // ==========================================================
   // Write-through read so a block written now is readable next cycle
   always_comb begin
      st_next = st_reg;
      if (wr_en) begin
         st_next.mem[wr_addr] = wr_data;
      end
      if (wr_en && (wr_addr == rd_addr)) begin
         st_next.rdata = wr_data;
      end else begin
         st_next.rdata = st_reg.mem[rd_addr];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign rd_data = st_reg.rdata;

endmodule : tglpm_fifo_mem

// [tglpm_mapper.sv]
// What this block does
// - Report input failure from recovered signal detect
// - Drive selected recovered clock as timing reference
// - Acquire 66-bit block lock by header hunting
// - Loss of block lock counts as input failure
// - Descramble payload, leave sync header untouched
// - Insert or delete idles to match gearbox rate
// - Replace failed or disabled input with fault blocks
// - Missing block at send time becomes fault block mid-frame, idle block between frames
// - Test pattern sends all-idle control blocks
// - Pattern mode switches only on block boundaries
// - Alternate blocks between the two gearbox lanes
// - Lane groups carry four 10G or one 40G
// - Mixes limited to twenty 10G within bandwidth
`timescale 1ns/100ps

module tglpm_mapper (
   input  wire logic                    ref_clk,
   input  wire logic                    reset_n,
   input  wire logic                    rx_signal_detect,
   input  wire logic                    rec_clk_tick,
   input  wire logic                    ref_select,
   input  wire logic                    input_enable,
   input  wire tglpm_pkg::tglpm_block_t rx_word,
   input  wire logic                    rx_word_valid,
   input  wire logic                    test_pattern_en,
   input  wire logic                    group_mode_40g,
   input  wire logic                    gbx_slot,
   output tglpm_pkg::tglpm_block_t      lane0_block,
   output logic                         lane0_valid,
   output tglpm_pkg::tglpm_block_t      lane1_block,
   output logic                         lane1_valid,
   output logic                         input_failed,
   output logic                         block_lock_out,
   output logic                         timing_ref_out
);

   // ==========================================================
   // State, one copy per instance so inputs never interact
   typedef struct packed {
      tglpm_pkg::tglpm_lock_e                 lock_st;
      logic                                   block_lock;
      logic [tglpm_pkg::OFF_W-1:0]            slip_off;
      logic                                   have_prev;
      tglpm_pkg::tglpm_block_t                prev_word;
      logic [tglpm_pkg::OFF_W-1:0]            sh_cnt;
      logic [4:0]                             invld_cnt;
      logic [tglpm_pkg::DSCR_W-1:0]           dscr;
      logic                                   failed;
      logic [tglpm_pkg::FIFO_AW-1:0]          wr_ptr;
      logic [tglpm_pkg::FIFO_AW-1:0]          rd_ptr;
      logic [tglpm_pkg::CNT_W-1:0]            count;
      logic                                   in_packet;
      logic                                   lane_sel;
      tglpm_pkg::tglpm_block_t                lane0_block;
      tglpm_pkg::tglpm_block_t                lane1_block;
      logic                                   lane0_valid;
      logic                                   lane1_valid;
      tglpm_pkg::tglpm_block_t                last_block;
      logic                                   timing_ref;
   } tglpm_state_s;

   tglpm_state_s            st_reg;
   tglpm_state_s            st_next;
   logic                    wr_en;
   logic                    rd_en;
   tglpm_pkg::tglpm_block_t wr_block;
   tglpm_pkg::tglpm_block_t rd_block;

   // ==========================================================
   // Helpers
   function automatic tglpm_pkg::tglpm_block_t align_block(
      input logic [2*tglpm_pkg::BLK_W-1:0] win,
      input logic [tglpm_pkg::OFF_W-1:0]   off);
      logic [2*tglpm_pkg::BLK_W-1:0] sh;
      sh = win >> off;
      return sh[tglpm_pkg::BLK_W-1:0];
   endfunction : align_block

   function automatic logic [tglpm_pkg::DSCR_W+tglpm_pkg::PAY_W-1:0] descramble(
      input logic [tglpm_pkg::PAY_W-1:0]  din,
      input logic [tglpm_pkg::DSCR_W-1:0] s_in);
      logic [tglpm_pkg::DSCR_W-1:0] s;
      logic [tglpm_pkg::PAY_W-1:0]  dout;
      s    = s_in;
      dout = '0;
      for (int i = 0; i < tglpm_pkg::PAY_W; i++) begin
         dout[i] = din[i] ^ s[tglpm_pkg::TAP_A] ^ s[tglpm_pkg::TAP_B];
         s       = {s[tglpm_pkg::DSCR_W-2:0], din[i]};
      end
      return {s, dout};
   endfunction : descramble

   function automatic logic is_ctrl(input tglpm_pkg::tglpm_block_t b);
      return b[tglpm_pkg::SH_HI:tglpm_pkg::SH_LO] == tglpm_pkg::SH_CTRL;
   endfunction : is_ctrl

   function automatic logic is_start(input tglpm_pkg::tglpm_block_t b);
      logic [7:0] t;
      t = b[tglpm_pkg::TYPE_HI:tglpm_pkg::TYPE_LO];
      return is_ctrl(b) && ((t == tglpm_pkg::TYPE_START0) ||
                            (t == tglpm_pkg::TYPE_STARTA) ||
                            (t == tglpm_pkg::TYPE_STARTB));
   endfunction : is_start

   // ==========================================================
   // Next state
   always_comb begin
      tglpm_pkg::tglpm_block_t                       aligned;
      logic                                          hdr_ok;
      logic [tglpm_pkg::DSCR_W+tglpm_pkg::PAY_W-1:0] dres;
      logic [tglpm_pkg::OFF_W-1:0]                   cnt_n;
      logic [4:0]                                    inv_n;
      logic                                          slip;
      logic                                          full;
      tglpm_pkg::tglpm_block_t                       out_blk;
      aligned = align_block({rx_word, st_reg.prev_word}, st_reg.slip_off);
      hdr_ok  = aligned[tglpm_pkg::SH_HI] ^ aligned[tglpm_pkg::SH_LO];
      dres    = descramble(aligned[tglpm_pkg::PAY_HI:tglpm_pkg::PAY_LO], st_reg.dscr);
      cnt_n   = st_reg.sh_cnt + tglpm_pkg::OFF_W'(1);
      inv_n   = st_reg.invld_cnt + 5'(!hdr_ok);
      slip    = 1'b0;
      full    = st_reg.count == tglpm_pkg::CNT_W'(tglpm_pkg::FIFO_ENTRIES);
      out_blk = tglpm_pkg::FAULT_BLOCK;
      st_next = st_reg;
      wr_en   = 1'b0;
      rd_en   = 1'b0;
      wr_block = {dres[tglpm_pkg::PAY_W-1:0], aligned[tglpm_pkg::SH_HI:tglpm_pkg::SH_LO]};

      st_next.failed      = !rx_signal_detect || !st_reg.block_lock || !input_enable;
      st_next.timing_ref  = ref_select && rec_clk_tick;
      st_next.lane0_valid = 1'b0;
      st_next.lane1_valid = 1'b0;

      // Header hunt and lock, one header test per received word
      if (rx_word_valid) begin
         st_next.prev_word = rx_word;
         st_next.have_prev = 1'b1;
         if (st_reg.have_prev) begin
            st_next.sh_cnt    = cnt_n;
            st_next.invld_cnt = inv_n;
            case (st_reg.lock_st)
               tglpm_pkg::LK_HUNT: begin
                  if (!hdr_ok) begin
                     slip = 1'b1;
                  end else if (cnt_n == tglpm_pkg::SH_WIN) begin
                     st_next.lock_st    = tglpm_pkg::LK_LOCKED;
                     st_next.block_lock = 1'b1;
                     st_next.sh_cnt     = '0;
                     st_next.invld_cnt  = '0;
                  end
               end
               tglpm_pkg::LK_LOCKED: begin
                  if (inv_n == tglpm_pkg::INVLD_MAX) begin
                     slip = 1'b1;
                  end else if (cnt_n == tglpm_pkg::SH_WIN) begin
                     st_next.sh_cnt    = '0;
                     st_next.invld_cnt = '0;
                  end
               end
               default: begin
                  slip = 1'b1;
               end
            endcase
            if (slip) begin
               st_next.lock_st    = tglpm_pkg::LK_HUNT;
               st_next.block_lock = 1'b0;
               st_next.sh_cnt     = '0;
               st_next.invld_cnt  = '0;
               st_next.slip_off   = (st_reg.slip_off == tglpm_pkg::OFF_LAST) ? '0 :
                                    st_reg.slip_off + tglpm_pkg::OFF_W'(1);
            end
            st_next.dscr = dres[tglpm_pkg::DSCR_W+tglpm_pkg::PAY_W-1:tglpm_pkg::PAY_W];
            // Idles are dropped only whole and only when the buffer runs high
            if (st_reg.block_lock && !st_reg.failed && hdr_ok && !full &&
                !((st_reg.count >= tglpm_pkg::HI_MARK) && (wr_block == tglpm_pkg::IDLE_BLOCK))) begin
               wr_en = 1'b1;
            end
         end
      end

      // One block per gearbox slot when not in 40G mode; slots pace the common clock rate
      if (gbx_slot && !group_mode_40g) begin
         rd_en = st_reg.count != '0;
         if (test_pattern_en) begin
            out_blk = tglpm_pkg::IDLE_BLOCK;
         end else if (st_reg.failed) begin
            out_blk = tglpm_pkg::FAULT_BLOCK;
         end else if (st_reg.count != '0) begin
            out_blk = rd_block;
         end else if (!st_reg.in_packet) begin
            out_blk = tglpm_pkg::IDLE_BLOCK;
         end else begin
            // Mid-frame underrun: idles may not be inserted here
            out_blk = tglpm_pkg::FAULT_BLOCK;
         end
         if (is_ctrl(out_blk)) begin
            st_next.in_packet = is_start(out_blk);
         end
         st_next.last_block = out_blk;
         if (st_reg.lane_sel) begin
            st_next.lane1_block = out_blk;
            st_next.lane1_valid = 1'b1;
         end else begin
            st_next.lane0_block = out_blk;
            st_next.lane0_valid = 1'b1;
         end
         st_next.lane_sel = !st_reg.lane_sel;
      end

      if (wr_en) begin
         st_next.wr_ptr = st_reg.wr_ptr + tglpm_pkg::FIFO_AW'(1);
      end
      if (rd_en) begin
         st_next.rd_ptr = st_reg.rd_ptr + tglpm_pkg::FIFO_AW'(1);
      end
      st_next.count = st_reg.count + tglpm_pkg::CNT_W'(wr_en) - tglpm_pkg::CNT_W'(rd_en);

      // A failed input flushes its buffer so stale frames never resume
      if (st_reg.failed) begin
         st_next.rd_ptr    = st_reg.wr_ptr;
         st_next.count     = '0;
         st_next.in_packet = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ==========================================================
   // Rate adaptation buffer; twenty 10G inputs fit the aggregate limit
   tglpm_fifo_mem u_fifo_mem (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .wr_en   (wr_en),
      .wr_addr (st_reg.wr_ptr),
      .wr_data (wr_block),
      .rd_addr (st_next.rd_ptr),
      .rd_data (rd_block)
   );

   assign lane0_block    = st_reg.lane0_block;
   assign lane0_valid    = st_reg.lane0_valid;
   assign lane1_block    = st_reg.lane1_block;
   assign lane1_valid    = st_reg.lane1_valid;
   assign input_failed   = st_reg.failed;
   assign block_lock_out = st_reg.block_lock;
   assign timing_ref_out = st_reg.timing_ref;

   // ==========================================================
   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   a_fail_report: assert property (!rx_signal_detect |=> input_failed)
      else $error("signal loss not reported as failure");
   a_timing_ref: assert property (ref_select && rec_clk_tick |=> timing_ref_out)
      else $error("selected recovered clock not driven out");
   a_lock_window: assert property ($rose(block_lock_out) |->
      ($past(st_reg.sh_cnt) == (tglpm_pkg::SH_WIN - 7'h01)) && ($past(st_reg.invld_cnt) == '0))
      else $error("lock gained without full header window");
   a_unlock_fails: assert property (!block_lock_out |=> input_failed)
      else $error("unlocked input not treated as failed");
   a_fail_fill: assert property (gbx_slot && !group_mode_40g && input_failed &&
      !test_pattern_en |=> st_reg.last_block == tglpm_pkg::FAULT_BLOCK)
      else $error("failed input not replaced by fault block");
   a_underrun_fill: assert property (gbx_slot && !group_mode_40g && !test_pattern_en &&
      !input_failed && (st_reg.count == '0) && st_reg.in_packet
      |=> st_reg.last_block == tglpm_pkg::FAULT_BLOCK)
      else $error("mid-frame underrun did not send fault block");
   a_idle_insert: assert property (gbx_slot && !group_mode_40g && !test_pattern_en &&
      !input_failed && (st_reg.count == '0) && !st_reg.in_packet
      |=> st_reg.last_block == tglpm_pkg::IDLE_BLOCK)
      else $error("idle not inserted between frames");
   a_test_idle: assert property (gbx_slot && !group_mode_40g && test_pattern_en
      |=> st_reg.last_block == tglpm_pkg::IDLE_BLOCK)
      else $error("test pattern block is not all idle");
   // Each taken slot lands on the lane that lane_sel named, then lane_sel flips
   a_lane_alt: assert property (gbx_slot && !group_mode_40g |=>
      (lane1_valid == $past(st_reg.lane_sel)) && (lane0_valid == !$past(st_reg.lane_sel)) &&
      (st_reg.lane_sel != $past(st_reg.lane_sel)))
      else $error("blocks not alternating between lanes");
   a_group_quiet: assert property (group_mode_40g |=> !lane0_valid && !lane1_valid)
      else $error("lanes active while group carries 40G");
   // A kept idle above the mark would let a slow gearbox creep the buffer to full
   a_idle_delete: assert property (rx_word_valid && !input_failed &&
      (st_reg.count >= tglpm_pkg::HI_MARK) && (wr_block == tglpm_pkg::IDLE_BLOCK) && !rd_en
      |=> st_reg.count == $past(st_reg.count))
      else $error("idle kept although buffer ran high");
   a_buf_bound: assert property (
      st_reg.count <= tglpm_pkg::CNT_W'(tglpm_pkg::FIFO_ENTRIES))
      else $error("rate buffer fill level beyond its depth");

   c_lock_gained: cover property ($rose(block_lock_out));
   c_fault_sent: cover property (lane1_valid && (lane1_block == tglpm_pkg::FAULT_BLOCK));
   c_traffic_sent: cover property (lane0_valid && !is_ctrl(lane0_block));
   c_pattern_switch: cover property (test_pattern_en ##1 !test_pattern_en);
   c_idle_dropped: cover property (rx_word_valid && !wr_en &&
      (wr_block == tglpm_pkg::IDLE_BLOCK) && (st_reg.count >= tglpm_pkg::HI_MARK));

endmodule : tglpm_mapper

// [tglpm_src_model.sv]
`timescale 1ns/100ps

// ==========================================================
// 10GBASE-R source: scrambles each payload, sends aligned words
module tglpm_src_model (
   input  wire logic               ref_clk,
   output tglpm_pkg::tglpm_block_t rx_word,
   output logic                    rx_word_valid
);
   logic [57:0] scr_reg;

   initial begin
      scr_reg = 58'h123456789abcdef;
      rx_word = 66'h0;
      rx_word_valid = 1'b0;
   end

   // Header leaves raw, payload bit 2 first, x^58 + x^39 + 1
   task automatic send_block(input tglpm_pkg::tglpm_block_t blk);
      tglpm_pkg::tglpm_block_t w;
      logic                    s;
      w = blk;
      for (int i = 2; i < 66; i++) begin
         s = blk[i] ^ scr_reg[38] ^ scr_reg[57];
         w[i] = s;
         scr_reg = {scr_reg[56:0], s};
      end
      @(posedge ref_clk);
      #1;
      rx_word = w;
      rx_word_valid = 1'b1;
      @(posedge ref_clk);
      #1;
      // Stale word is inverted so that it can never pass for fresh data
      rx_word = ~w;
      rx_word_valid = 1'b0;
   endtask : send_block
endmodule : tglpm_src_model

// [ten_g_lane_pair_mapper_test.sv]
`timescale 1ns/100ps

module ten_g_lane_pair_mapper_test;
   localparam tglpm_pkg::tglpm_block_t IDLE_EXP = {56'h0, 8'h1e, 2'b01};
   localparam tglpm_pkg::tglpm_block_t FLT_EXP  = {8'h01, 8'h00, 8'h00, 4'h0, 4'h0,
                                                   8'h01, 8'h00, 8'h00, 8'h55, 2'b01};
   logic                    ref_clk = 1'b0;
   logic                    reset_n;
   logic                    rx_signal_detect;
   logic                    rec_clk_tick;
   logic                    ref_select;
   logic                    input_enable;
   logic                    test_pattern_en;
   logic                    group_mode_40g;
   logic                    gbx_slot;
   tglpm_pkg::tglpm_block_t rx_word;
   logic                    rx_word_valid;
   tglpm_pkg::tglpm_block_t lane0_block;
   logic                    lane0_valid;
   tglpm_pkg::tglpm_block_t lane1_block;
   logic                    lane1_valid;
   logic                    input_failed;
   logic                    block_lock_out;
   logic                    timing_ref_out;
   logic                    next_lane = 1'b0;
   int                      error_cnt = 0;
   int                      checks_done = 0;

   always #2 ref_clk = ~ref_clk;

   tglpm_src_model src (
      .ref_clk       (ref_clk),
      .rx_word       (rx_word),
      .rx_word_valid (rx_word_valid)
   );

   tglpm_mapper DUT (
      .ref_clk           (ref_clk),
      .reset_n           (reset_n),
      .rx_signal_detect  (rx_signal_detect),
      .rec_clk_tick      (rec_clk_tick),
      .ref_select        (ref_select),
      .input_enable      (input_enable),
      .rx_word           (rx_word),
      .rx_word_valid     (rx_word_valid),
      .test_pattern_en   (test_pattern_en),
      .group_mode_40g    (group_mode_40g),
      .gbx_slot          (gbx_slot),
      .lane0_block       (lane0_block),
      .lane0_valid       (lane0_valid),
      .lane1_block       (lane1_block),
      .lane1_valid       (lane1_valid),
      .input_failed      (input_failed),
      .block_lock_out    (block_lock_out),
      .timing_ref_out    (timing_ref_out)
   );

   // ==========================================================
   // Comparison and transfer helpers
   task automatic chk_bit(input string what, input logic seen, input logic exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s expected %b seen %b", what, exp, seen);
      end
   endtask : chk_bit

   task automatic chk_blk(input string what, input tglpm_pkg::tglpm_block_t seen,
                          input tglpm_pkg::tglpm_block_t exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk_blk

   // The common gearbox rate is supplied from outside as slot pulses
   task automatic slot(output tglpm_pkg::tglpm_block_t blk);
      @(posedge ref_clk);
      #1;
      gbx_slot = 1'b1;
      @(posedge ref_clk);
      #1;
      gbx_slot = 1'b0;
      chk_bit("lane0_valid", lane0_valid, ~next_lane);
      chk_bit("lane1_valid", lane1_valid, next_lane);
      blk = next_lane ? lane1_block : lane0_block;
      next_lane = ~next_lane;
   endtask : slot

   // Leading idles may be inserted for rate matching, so skip a few
   task automatic slot_skip(output tglpm_pkg::tglpm_block_t blk);
      slot(blk);
      for (int k = 0; k < 4 && blk === IDLE_EXP; k++)
         slot(blk);
   endtask : slot_skip

   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : settle

   // ==========================================================
   // Scenarios
   task automatic t_ref();
      for (int i = 0; i < 4; i++) begin
         ref_select = i[1];
         rec_clk_tick = i[0];
         settle(1);
         chk_bit("timing_ref_out", timing_ref_out, i[1] & i[0]);
      end
      $display("test timing reference done");
   endtask : t_ref

   task automatic t_fault();
      tglpm_pkg::tglpm_block_t got;
      slot(got);
      chk_blk("unlocked lane0 fill", got, FLT_EXP);
      slot(got);
      chk_blk("unlocked lane1 fill", got, FLT_EXP);
      test_pattern_en = 1'b1;
      slot(got);
      chk_blk("pattern over fault", got, IDLE_EXP);
      test_pattern_en = 1'b0;
      $display("test fault fill done");
   endtask : t_fault

   task automatic t_40g();
      group_mode_40g = 1'b1;
      gbx_slot = 1'b1;
      settle(1);
      gbx_slot = 1'b0;
      for (int i = 0; i < 2; i++) begin
         chk_bit("lane0_valid in 40G", lane0_valid, 1'b0);
         chk_bit("lane1_valid in 40G", lane1_valid, 1'b0);
         settle(1);
      end
      group_mode_40g = 1'b0;
      $display("test 40G quiet done");
   endtask : t_40g

   task automatic t_lock();
      for (int i = 0; i < 64; i++)
         src.send_block(IDLE_EXP);
      chk_bit("block_lock_out after 64", block_lock_out, 1'b0);
      src.send_block(IDLE_EXP);
      chk_bit("block_lock_out after 65", block_lock_out, 1'b1);
      settle(1);
      chk_bit("input_failed locked", input_failed, 1'b0);
      $display("test lock done");
   endtask : t_lock

   task automatic t_data();
      tglpm_pkg::tglpm_block_t exp_b [7];
      tglpm_pkg::tglpm_block_t got;
      for (int i = 0; i < 7; i++) begin
         exp_b[i] = {64'h0123456789abcdef + 64'(i), 2'b10};
         src.send_block(exp_b[i]);
         // The buffer now sits at the delete mark, so the next two idles are dropped
         if (i == 5) begin
            src.send_block(IDLE_EXP);
            src.send_block(IDLE_EXP);
         end
      end
      src.send_block(IDLE_EXP);
      slot_skip(got);
      chk_blk("first data block", got, exp_b[0]);
      for (int i = 1; i < 6; i++) begin
         slot(got);
         chk_blk("data block", got, exp_b[i]);
      end
      slot(got);
      chk_blk("block after deleted idles", got, exp_b[6]);
      slot(got);
      chk_blk("empty buffer fill", got, IDLE_EXP);
      $display("test data path done");
   endtask : t_data

   task automatic t_frame();
      tglpm_pkg::tglpm_block_t start_b;
      tglpm_pkg::tglpm_block_t data_b;
      tglpm_pkg::tglpm_block_t got;
      start_b = {56'hd5555555555555, 8'h78, 2'b01};
      data_b = {64'hfeedf00dcafe1234, 2'b10};
      src.send_block(start_b);
      src.send_block(IDLE_EXP);
      slot_skip(got);
      chk_blk("frame start", got, start_b);
      slot(got);
      chk_blk("underrun in frame", got, FLT_EXP);
      test_pattern_en = 1'b1;
      slot(got);
      chk_blk("test pattern", got, IDLE_EXP);
      test_pattern_en = 1'b0;
      src.send_block(data_b);
      src.send_block(IDLE_EXP);
      slot_skip(got);
      chk_blk("block after pattern", got, data_b);
      $display("test frame and pattern done");
   endtask : t_frame

   task automatic t_fail();
      tglpm_pkg::tglpm_block_t got;
      input_enable = 1'b0;
      settle(2);
      chk_bit("input_failed disabled", input_failed, 1'b1);
      slot(got);
      chk_blk("disabled fill", got, FLT_EXP);
      input_enable = 1'b1;
      rx_signal_detect = 1'b0;
      settle(2);
      chk_bit("input_failed no signal", input_failed, 1'b1);
      rx_signal_detect = 1'b1;
      settle(2);
      chk_bit("input_failed restored", input_failed, 1'b0);
      for (int i = 0; i < 17; i++)
         src.send_block({64'h0, 2'b00});
      settle(2);
      chk_bit("block_lock_out lost", block_lock_out, 1'b0);
      chk_bit("input_failed lock lost", input_failed, 1'b1);
      slot(got);
      chk_blk("lock lost fill", got, FLT_EXP);
      $display("test failures done");
   endtask : t_fail

   // ==========================================================
   // Verdict
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude

   // The whole run needs well under 1500 cycles
   initial begin
      #40000;
      error_cnt++;
      $display("unexpected run length expected end seen watchdog");
      conclude();
   end

   initial begin
      reset_n = 1'b0;
      rx_signal_detect = 1'b1;
      rec_clk_tick = 1'b0;
      ref_select = 1'b0;
      input_enable = 1'b1;
      test_pattern_en = 1'b0;
      group_mode_40g = 1'b0;
      gbx_slot = 1'b0;
      settle(16);
      chk_bit("input_failed in reset", input_failed, 1'b0);
      chk_bit("lane0_valid in reset", lane0_valid, 1'b0);
      reset_n = 1'b1;
      settle(1);
      chk_bit("input_failed unlocked", input_failed, 1'b1);
      chk_bit("block_lock_out unlocked", block_lock_out, 1'b0);
      $display("test reset done");
      t_ref();
      t_fault();
      t_40g();
      t_lock();
      t_data();
      t_frame();
      t_fail();
      conclude();
   end
endmodule : ten_g_lane_pair_mapper_test
